// ---- logic/masout_dram_seq.sv ----
// DRAM access sequencer: row phase, column phase, refresh, strobe steering.
// Assumes one DRAM request at a time and a registered parent.
`timescale 1ns/1ps
module masout_dram_seq
(
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic start_i,
  input wire logic refresh_i,
  input wire logic interleave_i,
  input wire logic [1:0] bank_i,
  input wire logic [1:0] size_sel_i,
  input wire logic [31:0] addr_i,
  input wire logic [3:0] byte_lane_enable_n_i,
  input wire logic [7:0] beats_i,
  output logic [11:0] addr_o,
  output logic [3:0] row_strobe_n_o,
  output logic [7:0] column_strobe_n_o,
  output logic busy_o,
  output logic done_o
);
  import masout_pkg::*;
  masout_dram_st_t st_r, st_nxt;
  logic [11:0] addr_r;
  logic [3:0] ras_r;
  logic [7:0] cas_r;
  logic [7:0] left_r;
  logic [31:0] a_r;
  logic il_r;
  logic rf_r;
  logic [3:0] lanes_r;
  logic [3:0] ras_sel_r;
  wire last_w = (left_r == BURST_RST);
  wire leaf_w = addr_i[2];
  // Interleaved: even leaf uses 0 and 2, odd leaf 1 and 3, pair by bank bit 1
  wire [3:0] ras_il_w = 4'h1 << {bank_i[1], leaf_w};
  wire [3:0] ras_ni_w = 4'h1 << bank_i;
  wire [3:0] ras_pick_w = interleave_i ? ras_il_w : ras_ni_w;
  wire [7:0] cas_lane_w = il_r ? (a_r[2] ? {~lanes_r, 4'h0} : {4'h0, ~lanes_r}) : {~lanes_r, ~lanes_r};
  always_comb
  begin
    st_nxt = st_r;
    case (st_r)
      MASOUT_IDLE: if (start_i || refresh_i) st_nxt = MASOUT_ROW;
      MASOUT_ROW: st_nxt = MASOUT_COL;
      MASOUT_COL: if (last_w) st_nxt = MASOUT_DONE;
      MASOUT_DONE: st_nxt = MASOUT_IDLE;
      default: st_nxt = MASOUT_IDLE;
    endcase
  end
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      st_r <= MASOUT_IDLE;
      addr_r <= MUX_RST;
      ras_r <= RAS_IDLE;
      cas_r <= CAS_IDLE;
      left_r <= BURST_RST;
      a_r <= 32'h0000_0000;
      il_r <= 1'b0;
      rf_r <= 1'b0;
      lanes_r <= WSTB_IDLE;
      ras_sel_r <= 4'h0;
      done_o <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      done_o <= (st_r == MASOUT_DONE);
      case (st_r)
        MASOUT_IDLE:
          if (start_i || refresh_i)
          begin
            rf_r <= refresh_i && !start_i;
            a_r <= addr_i;
            il_r <= interleave_i;
            lanes_r <= byte_lane_enable_n_i;
            // Refresh is a single column cycle; a stray beat count would never count down
            left_r <= (refresh_i && !start_i) ? BURST_RST : beats_i;
            ras_sel_r <= (refresh_i && !start_i) ? 4'hf : ras_pick_w;
            addr_r <= masout_row(addr_i, size_sel_i);
          end
        MASOUT_ROW:
        begin
          ras_r <= ~ras_sel_r;
          cas_r <= CAS_IDLE;
        end
        MASOUT_COL:
        begin
          if (cas_r == CAS_IDLE || rf_r)
          begin
            // Column address and strobes move together; row strobe already low
            cas_r <= rf_r ? 8'h00 : ~cas_lane_w;
            if (cas_r == CAS_IDLE && !rf_r)
              addr_r <= masout_col(a_r, il_r);
          end
          if (cas_r != CAS_IDLE && !rf_r)
          begin
            left_r <= left_r - 8'h01;
            addr_r <= addr_r + 12'h001;
          end
          if (last_w && cas_r != CAS_IDLE)
            cas_r <= CAS_IDLE;
        end
        MASOUT_DONE:
        begin
          ras_r <= RAS_IDLE;
          cas_r <= CAS_IDLE;
        end
        default: ras_r <= RAS_IDLE;
      endcase
    end
  end
  assign addr_o = addr_r;
  assign row_strobe_n_o = ras_r;
  assign column_strobe_n_o = cas_r;
  assign busy_o = (st_r != MASOUT_IDLE);

  property p_ras_release;
    @(posedge sys_clk_i) disable iff (!arst_n_i) (st_r == MASOUT_DONE) |=> ras_r == RAS_IDLE;
  endproperty
  a_ras_release: assert property (p_ras_release) else $error("row strobe held after access");
  property p_ras_before_cas;
    @(posedge sys_clk_i) disable iff (!arst_n_i) (cas_r != CAS_IDLE && !rf_r) |-> ras_r != RAS_IDLE;
  endproperty
  a_ras_before_cas: assert property (p_ras_before_cas) else $error("column strobe without row strobe");
  property p_refresh_all;
    @(posedge sys_clk_i) disable iff (!arst_n_i) (rf_r && st_r == MASOUT_COL) |=> cas_r == 8'h00;
  endproperty
  a_refresh_all: assert property (p_refresh_all) else $error("refresh without all column strobes");
  property p_il_pair;
    @(posedge sys_clk_i) disable iff (!arst_n_i) (il_r && !rf_r && ras_r != RAS_IDLE) |->
      ((~ras_r & 4'h5) == 4'h0) || ((~ras_r & 4'ha) == 4'h0);
  endproperty
  a_il_pair: assert property (p_il_pair) else $error("leaf strobes mixed");
  property p_one_ras;
    @(posedge sys_clk_i) disable iff (!arst_n_i) (!rf_r) |-> $onehot0(~ras_r);
  endproperty
  a_one_ras: assert property (p_one_ras) else $error("several row strobes in access");
  c_dram_refresh: cover property (@(posedge sys_clk_i) disable iff (!arst_n_i) rf_r && cas_r == 8'h00);
  c_dram_il: cover property (@(posedge sys_clk_i) disable iff (!arst_n_i) il_r && ras_r != RAS_IDLE);
endmodule

// ---- logic/masout_pkg.sv ----
// Constants and types for the memory address and strobe output block.
// Assumes one 40 MHz clock and an active-low asynchronous reset.
// What this block does
// - Static banks: drive word address bits 13:2
// - Static burst: address increments per transfer
// - DRAM: row/column address 11:0 by geometry
// - Static write strobe n only for lane n
// - Write data valid at strobe rising edge
// - Row strobe only with valid row address
// - Row strobe deasserts after last transfer
// - Non-interleaved: row strobe n for bank n
// - Interleaved: strobes 0,2 even; 1,3 odd
// - Everything timed on the single clock
// - Column strobes with column address; all on refresh
// - One static bank select, held whole access
package masout_pkg;
  localparam int SRAM_LSB = 2;
  localparam int ROW_LSB = 11;
  localparam int COL_LSB = 2;
  localparam logic [11:0] MUX_RST = 12'h000;
  localparam logic [3:0] RAS_IDLE = 4'hf;
  localparam logic [7:0] CAS_IDLE = 8'hff;
  localparam logic [3:0] WSTB_IDLE = 4'hf;
  localparam logic [1:0] CE_IDLE = 2'h3;
  localparam logic [7:0] BURST_RST = 8'h00;

  typedef enum logic [1:0] {
    MASOUT_IDLE,
    MASOUT_ROW,
    MASOUT_COL,
    MASOUT_DONE
  } masout_dram_st_t;

  typedef enum logic [1:0] {
    MASOUT_S_IDLE,
    MASOUT_S_SETUP,
    MASOUT_S_STROBE,
    MASOUT_S_HOLD
  } masout_sram_st_t;

  // Row bits of the local address, selected by DRAM geometry
  function automatic logic [11:0] masout_row(input logic [31:0] a, input logic [1:0] sz);
    logic [31:0] s;
    s = a >> (ROW_LSB + sz);
    return s[11:0];
  endfunction

  // Column bits start at the word address, one bit higher when interleaved
  function automatic logic [11:0] masout_col(input logic [31:0] a, input logic il);
    logic [31:0] s;
    s = il ? (a >> (COL_LSB + 1)) : (a >> COL_LSB);
    return s[11:0];
  endfunction
endpackage

// ---- logic/masout_sram_seq.sv ----
// Static memory access sequencer: bank select, address, write strobes.
// Assumes requests are held stable until done pulses.
`timescale 1ns/1ps
module masout_sram_seq
(
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic start_i,
  input wire logic bank_i,
  input wire logic write_i,
  input wire logic [31:0] addr_i,
  input wire logic [3:0] byte_lane_enable_n_i,
  input wire logic [7:0] beats_i,
  output logic [11:0] addr_o,
  output logic [3:0] static_write_strobe_n_o,
  output logic [1:0] static_bank_select_n_o,
  output logic busy_o,
  output logic done_o
);
  import masout_pkg::*;
  masout_sram_st_t st_r, st_nxt;
  logic [7:0] left_r;
  logic [11:0] addr_r;
  logic [3:0] we_r;
  logic [1:0] ce_r;
  logic wr_r;
  logic [3:0] lanes_r;
  wire last_w = (left_r == BURST_RST);
  wire [1:0] ce_sel_w = bank_i ? 2'h1 : 2'h2;
  always_comb
  begin
    st_nxt = st_r;
    case (st_r)
      MASOUT_S_IDLE: if (start_i) st_nxt = MASOUT_S_SETUP;
      MASOUT_S_SETUP: st_nxt = MASOUT_S_STROBE;
      MASOUT_S_STROBE: st_nxt = MASOUT_S_HOLD;
      MASOUT_S_HOLD: st_nxt = last_w ? MASOUT_S_IDLE : MASOUT_S_SETUP;
      default: st_nxt = MASOUT_S_IDLE;
    endcase
  end
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      st_r <= MASOUT_S_IDLE;
      left_r <= BURST_RST;
      addr_r <= MUX_RST;
      we_r <= WSTB_IDLE;
      ce_r <= CE_IDLE;
      wr_r <= 1'b0;
      lanes_r <= WSTB_IDLE;
      done_o <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      done_o <= (st_r == MASOUT_S_HOLD) && last_w;
      if (st_r == MASOUT_S_IDLE && start_i)
      begin
        addr_r <= addr_i[SRAM_LSB +: 12];
        left_r <= beats_i;
        ce_r <= ce_sel_w;
        wr_r <= write_i;
        lanes_r <= byte_lane_enable_n_i;
      end
      if (st_r == MASOUT_S_HOLD && !last_w)
      begin
        addr_r <= addr_r + 12'h001;
        left_r <= left_r - 8'h01;
      end
      if (st_r == MASOUT_S_HOLD && last_w)
        ce_r <= CE_IDLE;
      // Strobe low one cycle; rises before address moves, data held through hold
      we_r <= (st_nxt == MASOUT_S_STROBE && wr_r) ? lanes_r : WSTB_IDLE;
    end
  end
  assign addr_o = addr_r;
  assign static_write_strobe_n_o = we_r;
  assign static_bank_select_n_o = ce_r;
  assign busy_o = (st_r != MASOUT_S_IDLE);

  property p_one_select;
    @(posedge sys_clk_i) disable iff (!arst_n_i) ce_r != 2'h0;
  endproperty
  a_one_select: assert property (p_one_select) else $error("both bank selects low");
  property p_we_lane;
    @(posedge sys_clk_i) disable iff (!arst_n_i) (~we_r & lanes_r) == 4'h0;
  endproperty
  a_we_lane: assert property (p_we_lane) else $error("strobe on unselected lane");
  property p_we_rise_addr;
    @(posedge sys_clk_i) disable iff (!arst_n_i) (we_r != WSTB_IDLE) |=> $stable(addr_r) && we_r == WSTB_IDLE;
  endproperty
  a_we_rise_addr: assert property (p_we_rise_addr) else $error("address moved at strobe rise");
  property p_burst_inc;
    @(posedge sys_clk_i) disable iff (!arst_n_i)
      (st_r == MASOUT_S_HOLD && !last_w) |=> addr_r == $past(addr_r) + 12'h001;
  endproperty
  a_burst_inc: assert property (p_burst_inc) else $error("burst address not incremented");
  c_sram_write: cover property (@(posedge sys_clk_i) disable iff (!arst_n_i) we_r != WSTB_IDLE);
endmodule

// ---- logic/masout_top.sv ----
// Memory address and strobe output pins of the local memory controller.
// Assumes one request at a time, held until done; all on sys_clk_i.
`timescale 1ns/1ps
module masout_top
(
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic req_i,
  input wire logic is_dram_i,
  input wire logic refresh_i,
  input wire logic write_i,
  input wire logic static_bank_i,
  input wire logic [1:0] dram_bank_i,
  input wire logic interleave_i,
  input wire logic [1:0] size_sel_i,
  input wire logic [31:0] local_addr_data_i,
  input wire logic [3:0] byte_lane_enable_n_i,
  input wire logic [7:0] beats_i,
  output logic [11:0] mem_mux_addr_o,
  output logic [3:0] static_write_strobe_n_o,
  output logic [3:0] row_strobe_n_o,
  output logic [7:0] column_strobe_n_o,
  output logic [1:0] static_bank_select_n_o,
  output logic done_o
);
  import masout_pkg::*;
  logic [11:0] s_addr, d_addr;
  logic [3:0] s_we, d_ras;
  logic [7:0] d_cas;
  logic [1:0] s_ce;
  logic s_busy, d_busy, s_done, d_done;
  logic [11:0] mux_r;
  logic [3:0] we_r, ras_r;
  logic [7:0] cas_r;
  logic [1:0] ce_r;
  logic done_r;
  // Held off while done drains out, so a request still held is not taken twice
  wire idle_w = !s_busy && !d_busy && !s_done && !d_done && !done_r;
  wire s_go_w = req_i && !is_dram_i && idle_w;
  wire d_go_w = req_i && is_dram_i && idle_w;
  wire [11:0] mux_w = d_busy ? d_addr : s_addr;

  masout_sram_seq i_masout_sram_seq (
    .sys_clk_i(sys_clk_i),
    .arst_n_i(arst_n_i),
    .start_i(s_go_w),
    .bank_i(static_bank_i),
    .write_i(write_i),
    .addr_i(local_addr_data_i),
    .byte_lane_enable_n_i(byte_lane_enable_n_i),
    .beats_i(beats_i),
    .addr_o(s_addr),
    .static_write_strobe_n_o(s_we),
    .static_bank_select_n_o(s_ce),
    .busy_o(s_busy),
    .done_o(s_done)
  );
  masout_dram_seq i_masout_dram_seq (
    .sys_clk_i(sys_clk_i),
    .arst_n_i(arst_n_i),
    .start_i(d_go_w),
    .refresh_i(refresh_i && idle_w && !req_i),
    .interleave_i(interleave_i),
    .bank_i(dram_bank_i),
    .size_sel_i(size_sel_i),
    .addr_i(local_addr_data_i),
    .byte_lane_enable_n_i(byte_lane_enable_n_i),
    .beats_i(beats_i),
    .addr_o(d_addr),
    .row_strobe_n_o(d_ras),
    .column_strobe_n_o(d_cas),
    .busy_o(d_busy),
    .done_o(d_done)
  );

  // One clock domain only; pins re-registered, adding one cycle to every strobe
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      mux_r <= MUX_RST;
      we_r <= WSTB_IDLE;
      ras_r <= RAS_IDLE;
      cas_r <= CAS_IDLE;
      ce_r <= CE_IDLE;
      done_r <= 1'b0;
    end
    else
    begin
      mux_r <= mux_w;
      we_r <= s_we;
      ras_r <= d_ras;
      cas_r <= d_cas;
      ce_r <= s_ce;
      done_r <= s_done || d_done;
    end
  end
  assign mem_mux_addr_o = mux_r;
  assign static_write_strobe_n_o = we_r;
  assign row_strobe_n_o = ras_r;
  assign column_strobe_n_o = cas_r;
  assign static_bank_select_n_o = ce_r;
  assign done_o = done_r;

  property p_sram_addr;
    @(posedge sys_clk_i) disable iff (!arst_n_i) s_go_w |-> ##2 mem_mux_addr_o == $past(local_addr_data_i[13:2], 2);
  endproperty
  a_sram_addr: assert property (p_sram_addr) else $error("static address not word address");
  property p_ras_row;
    @(posedge sys_clk_i) disable iff (!arst_n_i)
      $rose(ras_r != RAS_IDLE) |-> $stable(mem_mux_addr_o);
  endproperty
  a_ras_row: assert property (p_ras_row) else $error("row address changed as row strobe fell");
  property p_no_mix;
    @(posedge sys_clk_i) disable iff (!arst_n_i) !(ce_r != CE_IDLE && ras_r != RAS_IDLE);
  endproperty
  a_no_mix: assert property (p_no_mix) else $error("static and DRAM strobes together");
  c_burst: cover property (@(posedge sys_clk_i) disable iff (!arst_n_i) s_go_w && beats_i != 8'h00);
  c_done: cover property (@(posedge sys_clk_i) disable iff (!arst_n_i) done_o);
endmodule

// ---- sim/masout_mem_model.sv ----
// Memory side model: notes which strobes fell and latches mux addresses.
// Assumes registered controller outputs, all looked at on sys_clk_i.
`timescale 1ns/1ps
module masout_mem_model
(
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic clr_i,
  input wire logic [11:0] mem_mux_addr_i,
  input wire logic [3:0] static_write_strobe_n_i,
  input wire logic [3:0] row_strobe_n_i,
  input wire logic [7:0] column_strobe_n_i,
  input wire logic [1:0] static_bank_select_n_i,
  output logic [3:0] ras_seen_o,
  output logic [7:0] cas_seen_o,
  output logic [3:0] wstb_seen_o,
  output logic [1:0] ce_seen_o,
  output logic [11:0] row_addr_o,
  output logic [11:0] col_addr_o,
  output logic [11:0] s_first_o,
  output logic [11:0] s_last_o,
  output logic [7:0] s_steps_o,
  output logic err_o
);
  logic [11:0] a_q;
  logic [3:0] ras_q;
  logic [7:0] cas_q;
  logic [3:0] wstb_q;
  logic [1:0] ce_q;
  always @(posedge sys_clk_i or negedge arst_n_i)
  begin
    a_q <= mem_mux_addr_i;
    ras_q <= row_strobe_n_i;
    cas_q <= column_strobe_n_i;
    wstb_q <= static_write_strobe_n_i;
    ce_q <= static_bank_select_n_i;
    if (!arst_n_i || clr_i)
    begin
      {ras_seen_o, cas_seen_o, wstb_seen_o, ce_seen_o, err_o, s_steps_o} <= '0;
      {row_addr_o, col_addr_o, s_first_o, s_last_o} <= '0;
    end
    else
    begin
      ras_seen_o <= ras_seen_o | ~row_strobe_n_i;
      cas_seen_o <= cas_seen_o | ~column_strobe_n_i;
      wstb_seen_o <= wstb_seen_o | ~static_write_strobe_n_i;
      ce_seen_o <= ce_seen_o | ~static_bank_select_n_i;
      if (ras_q == 4'hf && row_strobe_n_i != 4'hf)
        row_addr_o <= mem_mux_addr_i;
      if (cas_q == 8'hff && column_strobe_n_i != 8'hff)
      begin
        col_addr_o <= mem_mux_addr_i;
        if (row_strobe_n_i == 4'hf)
          err_o <= 1'b1;
      end
      if (ce_q == 2'h3 && static_bank_select_n_i != 2'h3)
        s_first_o <= mem_mux_addr_i;
      if (static_bank_select_n_i != 2'h3)
        s_last_o <= mem_mux_addr_i;
      if (static_bank_select_n_i != 2'h3 && ce_q != 2'h3 && mem_mux_addr_i != a_q)
        s_steps_o <= s_steps_o + 8'h01;
      if (static_bank_select_n_i == 2'h0)
        err_o <= 1'b1;
      // Data is taken on the strobe's rising edge, so address and select must still hold
      if ((static_write_strobe_n_i & ~wstb_q) != 4'h0 && (mem_mux_addr_i != a_q || ce_q == 2'h3))
        err_o <= 1'b1;
    end
  end
endmodule

// ---- sim/masout_top_bench.sv ----
// Self-checking bench for the memory address and strobe outputs.
// Assumes the memory model beside the design; inputs change on falling edges.
`timescale 1ns/1ps
module masout_top_bench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic req = 1'b0, dr = 1'b0, rf = 1'b0, wr = 1'b0, sb = 1'b0, il = 1'b0, clr = 1'b0;
  logic [1:0] db = 2'h0, sz = 2'h0;
  logic [31:0] ad = 32'h0;
  logic [3:0] be = 4'hf;
  logic [7:0] bt = 8'h00;
  logic [11:0] mux_a, row_a, col_a, s_first, s_last;
  logic [3:0] wstb, ras, ras_s, wstb_s;
  logic [7:0] cas, cas_s, steps;
  logic [1:0] ce, ce_s;
  logic done, err;
  int n_mismatch = 0;
  int checks_done = 0;
  always #12.5 clk = ~clk;
  masout_top i_masout_top (.sys_clk_i(clk), .arst_n_i(rst_n), .req_i(req), .is_dram_i(dr), .refresh_i(rf),
    .write_i(wr), .static_bank_i(sb), .dram_bank_i(db), .interleave_i(il), .size_sel_i(sz),
    .local_addr_data_i(ad), .byte_lane_enable_n_i(be), .beats_i(bt), .mem_mux_addr_o(mux_a),
    .static_write_strobe_n_o(wstb), .row_strobe_n_o(ras), .column_strobe_n_o(cas),
    .static_bank_select_n_o(ce), .done_o(done));
  masout_mem_model i_masout_mem_model (.sys_clk_i(clk), .arst_n_i(rst_n), .clr_i(clr), .mem_mux_addr_i(mux_a),
    .static_write_strobe_n_i(wstb), .row_strobe_n_i(ras), .column_strobe_n_i(cas),
    .static_bank_select_n_i(ce), .ras_seen_o(ras_s), .cas_seen_o(cas_s), .wstb_seen_o(wstb_s),
    .ce_seen_o(ce_s), .row_addr_o(row_a), .col_addr_o(col_a), .s_first_o(s_first), .s_last_o(s_last),
    .s_steps_o(steps), .err_o(err));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // One access; the request holds until done is seen
  task automatic access(input logic d, w, s, input logic [1:0] b, input logic i, input logic [1:0] z,
    input logic [31:0] a, input logic [3:0] e, input logic [7:0] n_bt, input logic r);
    int n;
    @(negedge clk);
    clr = 1'b1;
    @(negedge clk);
    clr = 1'b0;
    {dr, wr, sb, db, il, sz, ad, be, bt} = {d, w, s, b, i, z, a, e, n_bt};
    req = !r;
    rf = r;
    n = 0;
    do
    begin
      @(posedge clk);
      #1;
      n++;
    end
    while (done !== 1'b1 && n < 80);
    // A refresh that never ends counts as well
    chk(n < 80, 1'b1);
    if (!r)
    begin
      chk(ras, 4'hf);
      if (d)
        chk(n, n_bt + 6);
      else
        chk(n, 3 * (n_bt + 1) + 2);
    end
    @(negedge clk);
    req = 1'b0;
    rf = 1'b0;
    repeat (4) @(negedge clk);
    chk(err, 1'b0);
  endtask
  task automatic t_reset();
    chk({mux_a, wstb, ras, cas, ce, done}, {12'h000, 4'hf, 4'hf, 8'hff, 2'h3, 1'b0});
    $display("test reset done");
  endtask
  task automatic t_static_write();
    access(1'b0, 1'b1, 1'b0, 2'h0, 1'b0, 2'h0, 32'h0000_3a5c, 4'b1010, 8'h00, 1'b0);
    chk(s_first, 12'he97);
    chk(wstb_s, 4'b0101);
    chk(ce_s, 2'b01);
    $display("test static write done");
  endtask
  task automatic t_static_burst();
    access(1'b0, 1'b0, 1'b1, 2'h0, 1'b0, 2'h0, 32'h0000_1ff8, 4'b0000, 8'h03, 1'b0);
    chk({s_first, s_last, steps}, {12'h7fe, 12'h801, 8'h03});
    chk(wstb_s, 4'h0);
    chk(ce_s, 2'b10);
    $display("test static burst done");
  endtask
  task automatic t_dram_flat();
    logic [31:0] a;
    a = 32'h0a5b_c3d4;
    for (int b = 0; b < 4; b++)
    begin
      access(1'b1, 1'b0, 1'b0, b[1:0], 1'b0, b[1:0], a, 4'b0110, 8'h02, 1'b0);
      chk(ras_s, 4'h1 << b);
      chk(row_a, (a >> (11 + b)) & 32'hfff);
      chk(col_a, (a >> 2) & 32'hfff);
      chk(cas_s, 8'h99);
    end
    $display("test dram flat done");
  endtask
  task automatic t_dram_leaf();
    logic [31:0] a;
    logic [1:0] b;
    for (int i = 0; i < 4; i++)
    begin
      a = 32'h0123_4560 | (i[0] << 2);
      b = {i[1], 1'b0};
      access(1'b1, 1'b0, 1'b0, b, 1'b1, 2'h1, a, 4'b0011, 8'h01, 1'b0);
      chk(ras_s, 4'h1 << {b[1], a[2]});
      chk(row_a, (a >> 12) & 32'hfff);
      chk(col_a, (a >> 3) & 32'hfff);
      chk(cas_s, a[2] ? 8'hc0 : 8'h0c);
    end
    $display("test dram leaf done");
  endtask
  task automatic t_refresh();
    access(1'b1, 1'b0, 1'b0, 2'h0, 1'b0, 2'h0, 32'h0, 4'hf, 8'h00, 1'b1);
    chk({ras_s, cas_s}, {4'hf, 8'hff});
    $display("test refresh done");
  endtask
  initial
  begin
    // Long enough for every access with slack for slow strobes
    #500000;
    n_mismatch++;
    wrap_up();
  end
  initial
  begin
    repeat (3) @(negedge clk);
    t_reset();
    rst_n = 1'b1;
    t_static_write();
    t_static_burst();
    t_dram_flat();
    t_dram_leaf();
    t_refresh();
    wrap_up();
  end
endmodule
